// File: core/lerc_pkg.sv
`default_nettype none
package lerc_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_RETRY  = 8'h04;
  localparam logic [7:0] ADDR_BUDGET = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_ISTAT  = 8'h10;
  localparam logic [7:0] ADDR_IMASK  = 8'h14;
  localparam logic [7:0] ADDR_GCOUNT = 8'h18;
  localparam logic [7:0] ADDR_GINDEX = 8'h1C;
  localparam logic [7:0] ADDR_GDATA  = 8'h20;
  localparam logic [7:0] ADDR_FINDEX = 8'h24;
  localparam logic [7:0] ADDR_FDATA  = 8'h28;
  localparam logic [7:0] ADDR_FCOUNT = 8'h2C;
  // CTRL field positions
  localparam int CTRL_ENABLE   = 0;
  localparam int CTRL_RD_REALL = 1;
  localparam int CTRL_WR_REALL = 2;
  localparam int CTRL_SUPPRESS = 3;
  localparam logic [3:0] CTRL_RST = 4'h7;
  // RETRY field positions
  localparam int RETRY_RD_LSB = 0;
  localparam int RETRY_WR_LSB = 8;
  localparam logic [4:0] RD_RETRY_MIN = 5'h01;
  localparam logic [4:0] RD_RETRY_MAX = 5'h14;
  localparam logic [4:0] RD_RETRY_RST = 5'h14;
  localparam logic [2:0] WR_RETRY_MAX = 3'h5;
  localparam logic [2:0] WR_RETRY_RST = 3'h5;
  localparam logic [15:0] BUDGET_RST = 16'hFFFF;
  // Interrupt status bits
  localparam int EV_RECOVERED = 0;
  localparam int EV_UNRECOV   = 1;
  localparam int EV_REALLOC   = 2;
  localparam int EV_BUDGET    = 3;
  localparam int NUM_EV       = 4;
  // Recovery levels
  localparam logic [3:0] RD_LEVELS = 4'hC;
  localparam logic [3:0] WR_LEVELS = 4'h5;
  // Timing: 10 us tick at 40 MHz
  localparam int  CLK_PERIOD_NS = 25;
  localparam int  TICK_NS       = 10000;
  localparam int  TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam int  TICKS_PER_MS  = 100;
  localparam real TICK_MS       = 0.01;
  // Per-block cumulative ceilings, ms
  localparam real RD_TIME_S1_MS = 124.32;
  localparam real WR_TIME_S0_MS = 35.94;
  localparam real WR_TIME_S1_MS = 53.91;
  localparam real WR_TIME_S2_MS = 79.89;
  localparam real WR_TIME_S3_MS = 97.86;
  localparam real WR_TIME_S4_MS = 175.85;
  localparam real WR_TIME_S5_MS = 421.79;
  localparam logic [19:0] RD_TICKS_S1 = 20'(int'($floor(RD_TIME_S1_MS / TICK_MS + 0.5)));
  localparam logic [5:0][19:0] WR_TICKS = {
    20'(int'($floor(WR_TIME_S5_MS / TICK_MS + 0.5))),
    20'(int'($floor(WR_TIME_S4_MS / TICK_MS + 0.5))),
    20'(int'($floor(WR_TIME_S3_MS / TICK_MS + 0.5))),
    20'(int'($floor(WR_TIME_S2_MS / TICK_MS + 0.5))),
    20'(int'($floor(WR_TIME_S1_MS / TICK_MS + 0.5))),
    20'(int'($floor(WR_TIME_S0_MS / TICK_MS + 0.5)))};

  typedef struct packed {
    logic        is_write;
    logic [31:0] lba;
  } lerc_err_t;

  typedef struct packed {
    logic        is_write;
    logic [3:0]  level;
    logic [2:0]  step;
    logic [31:0] lba;
  } lerc_step_t;

  typedef struct packed {
    logic        is_write;
    logic        recovered;
    logic        reallocated;
    logic [31:0] lba;
  } lerc_report_t;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_STEP    = 5'h02,
    ST_WAIT    = 5'h04,
    ST_REALLOC = 5'h08,
    ST_DONE    = 5'h10
  } lerc_state_t;
endpackage : lerc_pkg
`default_nettype wire

// File: core/lerc_grown_list.sv
`default_nettype none
module lerc_grown_list #(
  parameter int DEPTH = 64,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          clk,      // Clock
  input  wire logic          rst_n,    // Async reset
  input  wire logic          app_en,   // Append one entry
  input  wire logic [31:0]   app_lba,  // Entry to append
  input  wire logic [AW-1:0] rd_idx,   // Read index
  output logic      [31:0]   rd_data,  // Entry at index
  output logic      [AW:0]   count,    // Entries held
  output logic               full      // No room left
);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end

  logic [31:0] mem [DEPTH];
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;

  assign full  = cnt_q[AW];
  assign count = cnt_q;

  always_comb begin
    cnt_d = cnt_q;
    if (app_en && !full) cnt_d = cnt_q + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= '0;
    else cnt_q <= cnt_d;
  end

  // Append only; entries are never rewritten once logged
  always_ff @(posedge clk) begin
    if (app_en && !full) mem[cnt_q[AW-1:0]] <= app_lba;
    rd_data <= mem[rd_idx];
  end
endmodule : lerc_grown_list
`default_nettype wire

// File: core/lerc_ctrl.sv
`default_nettype none
// Functional notes
// - Twelve escalating read levels, five escalating write levels per block.
// - Each step is exactly one re-read or one re-write attempt.
// - Highest level reached follows the read or write retry setting.
// - Total recovery time per command capped by the command budget.
// - Reallocate only if side enable set, suppress clear, budget unspent.
// - Reallocation time is not charged to the command budget.
// - Suppress blocks reallocation; recovery still runs within limits.
// - Suppress set means no check condition is reported; the unrecovered interrupt status bit still sets.
// - Read retry accepts 1 to 20; each unit about five percent.
// - Read per-block ceiling about 124.32 ms per retry unit.
// - Write per-block ceiling from table, 35.94 to 421.79 ms.
// - Exhausted read limit ends command with check condition report, unless suppress is set.
// - Factory defect table is never modified.
// - Reallocated defects append to grown list; both lists readable.
// - Recovery runs only when enabled, using configured options.
module lerc_ctrl
  import lerc_pkg::*;
#(
  parameter int         GROWN_DEPTH = 64,
  parameter int         FDT_AW      = 8,
  parameter logic [2:0] STEPS       = 3'h2
) (
  input  wire logic              pclk,          // APB clock, 40 MHz
  input  wire logic              presetn,       // Async reset, active low
  input  wire logic [7:0]        paddr,         // APB address
  input  wire logic              psel,          // APB select
  input  wire logic              penable,       // APB enable
  input  wire logic              pwrite,        // APB write
  input  wire logic [31:0]       pwdata,        // APB write data
  output logic      [31:0]       prdata,        // APB read data
  output logic                   pready,        // APB ready
  output logic                   pslverr,       // APB error, unmapped address
  input  wire logic              cmd_start,     // New command starts
  input  wire logic              err_valid,     // Media error on a block
  input  wire lerc_err_t         err_in,        // Failing block
  output logic                   err_ready,     // Error accepted
  output logic                   step_req,      // One media attempt
  output lerc_step_t             step_info,     // Attempt details
  input  wire logic              step_done,     // Attempt finished
  input  wire logic              step_ok,       // Attempt succeeded
  output logic                   realloc_req,   // Reallocation request
  output logic      [31:0]       realloc_lba,   // Block to reallocate
  input  wire logic              realloc_done,  // Reallocation finished
  output logic                   done,          // Block handling finished
  output lerc_report_t           done_info,     // Outcome of the block
  output logic                   chk_cond,      // Unrecovered error report
  output logic      [FDT_AW-1:0] fdt_addr,      // Factory table index
  input  wire logic [31:0]       fdt_data,      // Factory table entry
  input  wire logic [FDT_AW:0]   fdt_count,     // Factory table size
  output logic                   irq            // Level interrupt
);
  localparam int GAW = $clog2(GROWN_DEPTH);

  initial begin
    if (STEPS == 3'h0) $error("STEPS must be at least one");
    if (FDT_AW < 1 || FDT_AW > 16) $error("FDT_AW out of range");
  end

  // Register state
  logic [3:0]        ctrl_q, ctrl_d;
  logic [4:0]        rdr_q, rdr_d;
  logic [2:0]        wrr_q, wrr_d;
  logic [15:0]       budget_q, budget_d;
  logic [NUM_EV-1:0] istat_q, istat_d;
  logic [NUM_EV-1:0] imask_q, imask_d;
  logic [GAW-1:0]    gidx_q, gidx_d;
  logic [FDT_AW-1:0] fidx_q, fidx_d;
  logic [31:0]       prdata_q, prdata_d;

  // Recovery state
  lerc_state_t  st_q, st_d;
  lerc_step_t   cur_q, cur_d;
  logic         rec_q, rec_d;
  logic         rea_q, rea_d;
  logic [19:0]  lba_t_q, lba_t_d;
  logic [8:0]   div_q, div_d;
  logic [6:0]   sub_q, sub_d;
  logic [15:0]  cms_q, cms_d;
  logic         bud_seen_q, bud_seen_d;

  logic         wr_acc, rd_setup, mapped;
  logic         tick, timing, bud_hit;
  logic [3:0]   max_lvl;
  logic [19:0]  lba_lim;
  logic         last_try, may_realloc, gdl_app;
  logic [NUM_EV-1:0] ev;
  logic [31:0]  gdata;
  logic [GAW:0] gcount;
  logic         gfull;

  lerc_grown_list #(.DEPTH(GROWN_DEPTH), .AW(GAW)) lerc_grown_list_inst (
    .clk     (pclk),
    .rst_n   (presetn),
    .app_en  (gdl_app),
    .app_lba (cur_q.lba),
    .rd_idx  (gidx_q),
    .rd_data (gdata),
    .count   (gcount),
    .full    (gfull)
  );

  // APB decode
  always_comb begin
    case (paddr)
      ADDR_CTRL, ADDR_RETRY, ADDR_BUDGET, ADDR_STATUS,
      ADDR_ISTAT, ADDR_IMASK, ADDR_GCOUNT, ADDR_GINDEX,
      ADDR_GDATA, ADDR_FINDEX, ADDR_FDATA, ADDR_FCOUNT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;
  assign wr_acc   = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign prdata   = prdata_q;
  assign fdt_addr = fidx_q;

  // Timebase: 10 us tick, only while attempts are in progress
  assign timing = (st_q == ST_STEP) || (st_q == ST_WAIT);
  assign tick   = timing && (div_q == 9'(TICK_CYC - 1));
  assign bud_hit = (cms_q >= budget_q);

  // Ceilings per block
  always_comb begin
    if (cur_q.is_write) begin
      max_lvl = (wrr_q == 3'h0) ? 4'h1 : {1'b0, wrr_q};
      lba_lim = WR_TICKS[wrr_q];
    end else begin
      // Nine bits: setting 20 gives 259 before the divide
      max_lvl = 4'((({4'h0, rdr_q} * 9'(RD_LEVELS)) + 9'h013) / 9'h014);
      lba_lim = 20'(rdr_q * RD_TICKS_S1);
    end
  end

  // Limit on this block reached: stop here
  assign last_try = ((cur_q.level >= max_lvl) && (cur_q.step == STEPS - 3'h1))
                    || (lba_t_q >= lba_lim) || bud_hit;

  // Side enable, suppress clear, budget unspent
  assign may_realloc = (cur_q.is_write ? ctrl_q[CTRL_WR_REALL] : ctrl_q[CTRL_RD_REALL])
  // Uses step_ok, as rec_q only settles with the outcome
                       && !ctrl_q[CTRL_SUPPRESS] && !bud_hit && !gfull
                       && (step_ok || cur_q.is_write);

  assign gdl_app = (st_q == ST_REALLOC) && realloc_done;

  // Handshake outputs
  assign err_ready   = (st_q == ST_IDLE);
  assign step_req    = (st_q == ST_STEP);
  assign step_info   = cur_q;
  assign realloc_req = (st_q == ST_REALLOC);
  assign realloc_lba = cur_q.lba;
  assign done        = (st_q == ST_DONE);
  assign done_info   = '{is_write: cur_q.is_write, recovered: rec_q,
                         reallocated: rea_q, lba: cur_q.lba};
  // Silent while suppressed
  assign chk_cond    = (st_q == ST_DONE) && !rec_q && !ctrl_q[CTRL_SUPPRESS];
  assign irq         = |(istat_q & imask_q);

  // Recovery sequencer
  always_comb begin
    st_d  = st_q;
    cur_d = cur_q;
    rec_d = rec_q;
    rea_d = rea_q;
    case (st_q)
      ST_IDLE: begin
        if (err_valid) begin
          cur_d.is_write = err_in.is_write;
          cur_d.lba      = err_in.lba;
          cur_d.level    = 4'h1;
          cur_d.step     = 3'h0;
          rec_d          = 1'b0;
          rea_d          = 1'b0;
          // Disabled or budget spent: no attempts
          if (!ctrl_q[CTRL_ENABLE] || bud_hit) st_d = ST_DONE;
          else st_d = ST_STEP;
        end
      end
      ST_STEP: st_d = ST_WAIT;
      ST_WAIT: begin
        if (step_done) begin
          if (step_ok || last_try) begin
            rec_d = step_ok;
            st_d  = ST_DONE;
          end else if (cur_q.step == STEPS - 3'h1) begin
            cur_d.level = cur_q.level + 4'h1;
            cur_d.step  = 3'h0;
            st_d        = ST_STEP;
          end else begin
            cur_d.step = cur_q.step + 3'h1;
            st_d       = ST_STEP;
          end
        end
      end
      ST_REALLOC: begin
        if (realloc_done) begin
          rea_d = 1'b1;
          st_d  = ST_DONE;
        end
      end
      ST_DONE: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
    // Outcome settled: divert through reallocation when allowed
    if (st_q == ST_WAIT && st_d == ST_DONE) begin
      if (may_realloc) st_d = ST_REALLOC;
    end
  end

  // Timers
  always_comb begin
    div_d      = div_q;
    sub_d      = sub_q;
    cms_d      = cms_q;
    lba_t_d    = lba_t_q;
    bud_seen_d = bud_seen_q;
    if (timing) div_d = tick ? 9'h000 : div_q + 9'h001;
    if (tick) begin
      lba_t_d = (lba_t_q == 20'hFFFFF) ? lba_t_q : lba_t_q + 20'h00001;
      if (sub_q == 7'(TICKS_PER_MS - 1)) begin
        sub_d = 7'h00;
        if (cms_q != 16'hFFFF) cms_d = cms_q + 16'h0001;
      end else begin
        sub_d = sub_q + 7'h01;
      end
    end
    if (st_q == ST_IDLE && err_valid) lba_t_d = 20'h00000;
    if (bud_hit) bud_seen_d = 1'b1;
    if (cmd_start) begin
      sub_d      = 7'h00;
      cms_d      = 16'h0000;
      bud_seen_d = 1'b0;
    end
  end

  // Events
  always_comb begin
    ev = '0;
    ev[EV_RECOVERED] = (st_q == ST_DONE) && rec_q;
    ev[EV_UNRECOV]   = (st_q == ST_DONE) && !rec_q;
    ev[EV_REALLOC]   = gdl_app;
    ev[EV_BUDGET]    = bud_hit && !bud_seen_q;
  end

  // Register writes and read data
  always_comb begin
    ctrl_d   = ctrl_q;
    rdr_d    = rdr_q;
    wrr_d    = wrr_q;
    budget_d = budget_q;
    imask_d  = imask_q;
    gidx_d   = gidx_q;
    fidx_d   = fidx_q;
    istat_d  = istat_q;
    prdata_d = prdata_q;
    if (wr_acc) begin
      case (paddr)
        ADDR_CTRL: ctrl_d = pwdata[3:0];
        ADDR_RETRY: begin
          // Out-of-range settings leave the old value in place
          if (pwdata[RETRY_RD_LSB +: 5] >= RD_RETRY_MIN
              && pwdata[RETRY_RD_LSB +: 5] <= RD_RETRY_MAX)
            rdr_d = pwdata[RETRY_RD_LSB +: 5];
          if (pwdata[RETRY_WR_LSB +: 3] <= WR_RETRY_MAX)
            wrr_d = pwdata[RETRY_WR_LSB +: 3];
        end
        ADDR_BUDGET: budget_d = pwdata[15:0];
        ADDR_ISTAT:  istat_d  = istat_q & ~pwdata[NUM_EV-1:0];
        ADDR_IMASK:  imask_d  = pwdata[NUM_EV-1:0];
        ADDR_GINDEX: gidx_d   = pwdata[GAW-1:0];
        ADDR_FINDEX: fidx_d   = pwdata[FDT_AW-1:0];
        default: ;
      endcase
    end
    // Set wins over a same-cycle clear
    istat_d = istat_d | ev;
    if (rd_setup) begin
      case (paddr)
        ADDR_CTRL:   prdata_d = {28'h0, ctrl_q};
        ADDR_RETRY:  prdata_d = {21'h0, wrr_q, 3'h0, rdr_q};
        ADDR_BUDGET: prdata_d = {16'h0, budget_q};
        ADDR_STATUS: prdata_d = {15'h0, bud_hit, 4'h0, cur_q.level, 3'h0, st_q};
        ADDR_ISTAT:  prdata_d = {28'h0, istat_q};
        ADDR_IMASK:  prdata_d = {28'h0, imask_q};
        ADDR_GCOUNT: prdata_d = 32'(gcount);
        ADDR_GINDEX: prdata_d = 32'(gidx_q);
        ADDR_GDATA:  prdata_d = gdata;
        ADDR_FINDEX: prdata_d = 32'(fidx_q);
        ADDR_FDATA:  prdata_d = fdt_data;
        ADDR_FCOUNT: prdata_d = 32'(fdt_count);
        default:     prdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= CTRL_RST;
      rdr_q      <= RD_RETRY_RST;
      wrr_q      <= WR_RETRY_RST;
      budget_q   <= BUDGET_RST;
      istat_q    <= '0;
      imask_q    <= '0;
      gidx_q     <= '0;
      fidx_q     <= '0;
      prdata_q   <= 32'h0;
      st_q       <= ST_IDLE;
      cur_q      <= '0;
      rec_q      <= 1'b0;
      rea_q      <= 1'b0;
      lba_t_q    <= 20'h00000;
      div_q      <= 9'h000;
      sub_q      <= 7'h00;
      cms_q      <= 16'h0000;
      bud_seen_q <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      rdr_q      <= rdr_d;
      wrr_q      <= wrr_d;
      budget_q   <= budget_d;
      istat_q    <= istat_d;
      imask_q    <= imask_d;
      gidx_q     <= gidx_d;
      fidx_q     <= fidx_d;
      prdata_q   <= prdata_d;
      st_q       <= st_d;
      cur_q      <= cur_d;
      rec_q      <= rec_d;
      rea_q      <= rea_d;
      lba_t_q    <= lba_t_d;
      div_q      <= div_d;
      sub_q      <= sub_d;
      cms_q      <= cms_d;
      bud_seen_q <= bud_seen_d;
    end
  end
endmodule : lerc_ctrl
`default_nettype wire

// File: test/lerc_chk.sv
`default_nettype none
module lerc_chk
  import lerc_pkg::*;
#(
  parameter logic [2:0] STEPS = 3'h2
) (
  input wire logic         pclk,         // Clock
  input wire logic         presetn,      // Reset
  input wire logic         err_ready,    // Idle
  input wire logic         step_req,     // Attempt
  input wire lerc_step_t   step_info,    // Attempt info
  input wire logic         step_done,    // Attempt end
  input wire logic         step_ok,      // Attempt good
  input wire logic         realloc_req,  // Realloc
  input wire logic         realloc_done, // Realloc end
  input wire logic         done,         // Block end
  input wire lerc_report_t done_info,    // Outcome
  input wire logic         chk_cond      // Check condition
);
  logic [3:0] lvl_q, lvl_d;
  logic       busy_q, busy_d;
  always_comb begin
    lvl_d  = done ? 4'h0 : (step_req ? step_info.level : lvl_q);
    busy_d = step_req | (busy_q & ~step_done);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_q  <= 4'h0;
      busy_q <= 1'b0;
    end else begin
      lvl_q  <= lvl_d;
      busy_q <= busy_d;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence good_step_s; step_done && step_ok; endsequence
  sequence realloc_end_s; realloc_req && realloc_done; endsequence
  one_attempt_a: assert property (step_req |-> !busy_q)
    else $error("attempt issued while one is outstanding");
  step_index_a: assert property (step_req |-> step_info.step < STEPS)
    else $error("step index beyond steps per level");
  level_walk_a: assert property (step_req |-> (step_info.level == lvl_q + 4'h1) ||
    (step_info.level == lvl_q && lvl_q != 4'h0)) else $error("level did not advance by one");
  level_cap_a: assert property (step_req |-> step_info.level <= (step_info.is_write ? WR_LEVELS : RD_LEVELS))
    else $error("level above the level count");
  stop_on_ok_a: assert property (good_step_s |=> (realloc_req || done) && !step_req)
    else $error("attempts continued after success");
  realloc_hold_a: assert property (realloc_req && !realloc_done |=> realloc_req)
    else $error("realloc request dropped early");
  realloc_end_a: assert property (realloc_end_s |=> done && done_info.reallocated)
    else $error("realloc end not reported");
  read_realloc_a: assert property (done && done_info.reallocated && !done_info.is_write |-> done_info.recovered)
    else $error("lost read block reallocated");
  chk_only_a: assert property (chk_cond |-> done && !done_info.recovered)
    else $error("check condition without unrecovered block");
  idle_after_a: assert property (done |=> err_ready && !done)
    else $error("not idle after done");
  idle_quiet_a: assert property (err_ready |-> !step_req && !realloc_req)
    else $error("media activity while idle");
endmodule : lerc_chk

bind lerc_ctrl lerc_chk #(.STEPS(STEPS)) lerc_chk_inst (
  .pclk(pclk), .presetn(presetn), .err_ready(err_ready), .step_req(step_req), .step_info(step_info),
  .step_done(step_done), .step_ok(step_ok), .realloc_req(realloc_req), .realloc_done(realloc_done),
  .done(done), .done_info(done_info), .chk_cond(chk_cond));
`default_nettype wire

// File: test/lerc_media_model.sv
`default_nettype none
module lerc_media_model
  import lerc_pkg::*;
(
  input  wire logic       pclk,         // Clock
  input  wire logic       presetn,      // Reset
  input  wire logic       step_req,     // Attempt
  input  wire lerc_step_t step_info,    // Attempt info
  output logic            step_done,    // Attempt end
  output logic            step_ok,      // Attempt good
  input  wire logic       realloc_req,  // Realloc
  output logic            realloc_done, // Realloc end
  input  wire logic [7:0] fdt_addr,     // Table index
  output logic [31:0]     fdt_data,     // Table entry
  output logic [8:0]      fdt_count,    // Table size
  input  wire logic [7:0] nfail,        // Failures before success
  input  wire logic [7:0] lat           // Answer delay, 1 or more
);
  int n;
  // Fixed content: nothing can write it
  assign fdt_count = 9'h010;
  assign fdt_data  = 32'hFAC70000 | {24'h0, fdt_addr};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_done    <= 1'b0;
      step_ok      <= 1'b0;
      realloc_done <= 1'b0;
      n = 0;
    end else if (step_req) begin
      n = (step_info.level == 4'h1 && step_info.step == 3'h0) ? 0 : n + 1;
      repeat (lat - 1) @(posedge pclk);
      step_done <= 1'b1;
      step_ok   <= (n >= nfail);
      @(posedge pclk);
      step_done <= 1'b0;
      // Released: inverse of the last value
      step_ok   <= (n < nfail);
    end else if (realloc_req && !realloc_done) begin
      repeat (lat) @(posedge pclk);
      realloc_done <= 1'b1;
      @(posedge pclk);
      realloc_done <= 1'b0;
    end
  end
endmodule : lerc_media_model
`default_nettype wire

// File: test/lerc_ctrl_tb.sv
`default_nettype none
module lerc_ctrl_tb
  import lerc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, cmd_start, err_valid, err_ready;
  logic         step_req, step_done, step_ok, realloc_req, realloc_done, done, chk_cond, irq;
  logic [7:0]   paddr, fdt_addr, nfail, lat;
  logic [31:0]  pwdata, prdata, realloc_lba, fdt_data, glba;
  logic [8:0]   fdt_count;
  lerc_err_t    err_in;
  lerc_step_t   step_info;
  lerc_report_t done_info;
  lerc_step_t   sq[$];
  logic [35:0]  dq[$];
  logic [32:0]  rq[$];
  logic [3:0]   ctrl;
  logic [4:0]   rret;
  logic [2:0]   wret;
  logic         nobud;
  int           seed = 32'hC348;
  int           fails, n_compared, gc, i;

  lerc_ctrl lerc_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_start(cmd_start),
    .err_valid(err_valid), .err_in(err_in), .err_ready(err_ready), .step_req(step_req), .step_info(step_info),
    .step_done(step_done), .step_ok(step_ok), .realloc_req(realloc_req), .realloc_lba(realloc_lba),
    .realloc_done(realloc_done), .done(done), .done_info(done_info), .chk_cond(chk_cond),
    .fdt_addr(fdt_addr), .fdt_data(fdt_data), .fdt_count(fdt_count), .irq(irq));
  lerc_media_model lerc_media_model_inst (
    .pclk(pclk), .presetn(presetn), .step_req(step_req), .step_info(step_info), .step_done(step_done),
    .step_ok(step_ok), .realloc_req(realloc_req), .realloc_done(realloc_done), .fdt_addr(fdt_addr),
    .fdt_data(fdt_data), .fdt_count(fdt_count), .nfail(nfail), .lat(lat));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // One failing block; nf failed attempts before the media succeeds
  task automatic blk(input logic w, input int nf);
    int lv, a, tot;
    logic rec, rea;
    logic [31:0] lba;
    lba = $random(seed);
    lv  = w ? ((wret == 3'h0) ? 1 : int'(wret)) : (int'(rret) * 12 + 19) / 20;
    if (!ctrl[0] || nobud) lv = 0;
    tot = (nf + 1 < 2 * lv) ? nf + 1 : 2 * lv;
    rec = nf < 2 * lv;
    for (a = 0; a < tot; a++) sq.push_back({w, 4'(a / 2 + 1), 3'(a % 2), lba});
    rea = (lv > 0) && !ctrl[3] && (w ? ctrl[2] : ctrl[1] && rec);
    dq.push_back({!rec && !ctrl[3], w, rec, rea, lba});
    if (rea) begin
      gc++;
      glba = lba;
    end
    nfail <= 8'(nf);
    lat   <= 8'(1 + ($random(seed) & 3));
    cmd_start <= 1'b1;
    @(posedge pclk);
    cmd_start <= 1'b0;
    err_valid <= 1'b1;
    err_in    <= {w, lba};
    @(posedge pclk);
    while (err_ready !== 1'b1) @(posedge pclk);
    err_valid <= 1'b0;
    for (a = 0; a < 400 && done !== 1'b1; a++) @(posedge pclk);
    // Let the monitor take the outcome off the queue first
    @(posedge pclk);
    check(sq.size() + dq.size(), 0, "leftover results");
  endtask : blk

  always @(posedge pclk) begin
    if (presetn === 1'b1) begin
      if (step_req === 1'b1) check(64'(step_info), sq.size() ? 64'(sq.pop_front()) : {64{1'b1}}, "attempt");
      if (realloc_req === 1'b1)
        check(realloc_lba, dq.size() ? 64'(dq[0][31:0]) : {64{1'b1}}, "realloc block");
      if (done === 1'b1) check({chk_cond, done_info}, dq.size() ? 64'(dq.pop_front()) : {64{1'b1}}, "outcome");
      if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0)
        check({pslverr, prdata}, rq.size() ? 64'(rq.pop_front()) : {64{1'b1}}, "read");
    end
  end

  initial begin
    #2000000;
    fails++;
    $display("FAIL t=%0t watchdog expired", $time);
    tally_and_finish;
  end

  initial begin
    {presetn, psel, penable, pwrite, cmd_start, err_valid} = 6'h0;
    {paddr, pwdata, err_in, nfail, lat} = '0;
    {ctrl, rret, wret, nobud, gc} = {4'h7, 5'h14, 3'h5, 1'b0, 32'h0};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CTRL, 33'h000000007);
    rd(ADDR_RETRY, 33'h000000514);
    rd(ADDR_BUDGET, 33'h00000FFFF);
    rd(ADDR_IMASK, 33'h0);
    rd(8'h3C, 33'h100000000);
    $display("reset values done");
    // Out-of-range retry fields keep the old value
    apb(1'b1, ADDR_RETRY, 32'h500);
    rd(ADDR_RETRY, 33'h514);
    apb(1'b1, ADDR_RETRY, 32'h315);
    rd(ADDR_RETRY, 33'h314);
    apb(1'b1, ADDR_RETRY, 32'h601);
    rd(ADDR_RETRY, 33'h301);
    apb(1'b1, ADDR_RETRY, 32'h001);
    rd(ADDR_RETRY, 33'h001);
    {rret, wret} = {5'h01, 3'h0};
    blk(1'b0, 5);
    blk(1'b1, 0);
    apb(1'b1, ADDR_RETRY, 32'h514);
    {rret, wret} = {5'h14, 3'h5};
    blk(1'b0, 99);
    blk(1'b0, 7);
    blk(1'b1, 99);
    $display("retry limits done");
    for (i = 0; i < 4; i++) begin
      ctrl = (i == 0) ? 4'hF : (i == 1) ? 4'h9 : (i == 2) ? 4'h1 : 4'h0;
      apb(1'b1, ADDR_CTRL, {28'h0, ctrl});
      blk(1'b0, 3);
      blk(1'b1, 99);
    end
    $display("realloc and suppress done");
    ctrl = 4'h7;
    apb(1'b1, ADDR_CTRL, 32'h7);
    apb(1'b1, ADDR_BUDGET, 32'h0);
    nobud = 1'b1;
    blk(1'b0, 0);
    $display("budget done");
    rd(ADDR_GCOUNT, 33'(gc));
    apb(1'b1, ADDR_GINDEX, 32'(gc - 1));
    rd(ADDR_GDATA, {1'b0, glba});
    rd(ADDR_FCOUNT, 33'h10);
    apb(1'b1, ADDR_FINDEX, 32'h3);
    rd(ADDR_FDATA, 33'hFAC70003);
    apb(1'b1, ADDR_FDATA, 32'h0);
    rd(ADDR_FDATA, 33'hFAC70003);
    $display("defect lists done");
    rd(ADDR_ISTAT, 33'hF);
    @(negedge pclk);
    check(irq, 0, "irq masked");
    apb(1'b1, ADDR_IMASK, 32'h2);
    @(negedge pclk);
    check(irq, 1, "irq raised");
    apb(1'b1, ADDR_ISTAT, 32'h2);
    rd(ADDR_ISTAT, 33'hD);
    @(negedge pclk);
    check(irq, 0, "irq cleared");
    $display("interrupts done");
    tally_and_finish;
  end
endmodule : lerc_ctrl_tb
`default_nettype wire
